// file: rtl/ett_timer8.sv
/*
 * 8-bit down counter with control, status, interrupt and pin routing,
 * reached over a zero-wait APB slave.
 * Assumes one clock mclk and port_out_data from logic on that clock.
 */
`timescale 1ns/100ps
`include "ett_map.svh"

module ett_timer8 import ett_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        port_out_data,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             timer_output_port_pin
);

	ett_ctrl_t  ctrl_reg;       // control fields
	ett_state_t state_reg;      // run state
	logic [7:0] count_reg;      // current count
	logic [7:0] reload_reg;     // programmed initial count
	logic [2:0] shared_reg;     // writable upper shared bits
	logic [3:0] div_reg;        // free running prescaler
	logic       timer_out_reg;  // timer output level
	logic       istat_reg;      // interrupt status, read clears
	logic       imask_reg;      // interrupt mask
	logic       tick;           // selected count enable
	logic       tc;             // terminal count pulse
	logic       access;         // apb access phase
	logic       setup;          // apb setup phase
	logic       wr;             // write completes
	logic       rd;             // read completes
	logic [5:0] idx;            // word index
	logic       aligned;        // byte offset zero
	logic       hit_ctrl;       // control register hit
	logic       hit_shared;     // shared control hit
	logic       hit_reload;     // initial count hit
	logic       hit_count;      // count readback hit
	logic       hit_istat;      // interrupt status hit
	logic       hit_imask;      // interrupt mask hit
	logic       mapped;         // any register hit
	logic       wr_ctrl;        // control write
	logic [31:0] rdata_next;    // read mux

	// apb decode
	assign setup      = psel & ~penable;
	assign access     = psel & penable;
	assign wr         = access & pwrite;
	assign rd         = access & ~pwrite;
	assign idx        = paddr[7:2];
	assign aligned    = (paddr[1:0] == 2'b00);
	assign hit_ctrl   = aligned && (idx == `ETT_CTRL_IDX);
	assign hit_shared = aligned && (idx == `ETT_SHARED_IDX);
	assign hit_reload = aligned && (idx == `ETT_RELOAD_IDX);
	assign hit_count  = aligned && (idx == `ETT_COUNT_IDX);
	assign hit_istat  = aligned && (idx == `ETT_ISTAT_IDX);
	assign hit_imask  = aligned && (idx == `ETT_IMASK_IDX);
	assign mapped     = hit_ctrl | hit_shared | hit_reload | hit_count
	                  | hit_istat | hit_imask;
	assign wr_ctrl    = wr & hit_ctrl;

	// zero wait states, error on unmapped access
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// read mux, reserved bits of shared register read ones
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit_ctrl) begin
			rdata_next[`ETT_EN_BIT]                  = (state_reg == ETT_RUN);
			rdata_next[`ETT_SINGLE_BIT]              = ctrl_reg.single;
			rdata_next[`ETT_TOUT_BIT]                = ctrl_reg.timeout;
			rdata_next[`ETT_CSEL_HI:`ETT_CSEL_LO]    = ctrl_reg.clk_sel;
			rdata_next[`ETT_INTEN_BIT]               = ctrl_reg.int_en;
			rdata_next[`ETT_PINSEL_BIT]              = ctrl_reg.pin_sel;
		end else if (hit_shared) begin
			rdata_next[7:0] = {shared_reg, `ETT_SHARED_RSV};
		end else if (hit_reload) begin
			rdata_next[7:0] = reload_reg;
		end else if (hit_count) begin
			rdata_next[7:0] = count_reg;
		end else if (hit_istat) begin
			rdata_next[0] = istat_reg;
		end else if (hit_imask) begin
			rdata_next[0] = imask_reg;
		end
	end

	// read data captured in setup, stable through access
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rdata_next;
		end
	end

	// prescaler never restarts, so first tick is unaligned
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end

	// clock select: divide by 1, 2, 4 or 8
	always_comb begin
		unique case (ctrl_reg.clk_sel)
			2'd0: tick = 1'b1;
			2'd1: tick = div_reg[0];
			2'd2: tick = &div_reg[1:0];
			2'd3: tick = &div_reg[2:0];
		endcase
	end

	// terminal count when zero is counted past
	assign tc = (state_reg == ETT_RUN) && tick && (count_reg == 8'h00);

	// run state machine
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ETT_IDLE;
		end else begin
			unique case (state_reg)
				ETT_IDLE: begin
					if (wr_ctrl && pwdata[`ETT_EN_BIT]) begin
						state_reg <= ETT_RUN;
					end
				end
				ETT_RUN: begin
					if (wr_ctrl && !pwdata[`ETT_EN_BIT]) begin
						state_reg <= ETT_IDLE;
					end else if (tc && ctrl_reg.single) begin
						state_reg <= ETT_IDLE;
					end
				end
			endcase
		end
	end

	// counter: load on start, count down, reload in modulo mode
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 8'h00;
		end else if (state_reg == ETT_IDLE) begin
			if (wr_ctrl && pwdata[`ETT_EN_BIT]) begin
				count_reg <= reload_reg;
			end
		end else if (tick) begin
			if (count_reg != 8'h00) begin
				count_reg <= count_reg - 8'h01;
			end else if (!ctrl_reg.single) begin
				count_reg <= reload_reg;
			end
			// single-pass keeps zero, no reload
		end
	end

	// control fields; terminal count beats a same-cycle clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg.single  <= pwdata[`ETT_SINGLE_BIT];
				ctrl_reg.clk_sel <= pwdata[`ETT_CSEL_HI:`ETT_CSEL_LO];
				ctrl_reg.int_en  <= pwdata[`ETT_INTEN_BIT];
				ctrl_reg.pin_sel <= pwdata[`ETT_PINSEL_BIT];
			end
			if (tc) begin
				ctrl_reg.timeout <= 1'b1;
			end else if (wr_ctrl && pwdata[`ETT_TOUT_BIT]) begin
				ctrl_reg.timeout <= 1'b0;
			end
		end
	end

	// initial count and shared control storage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reload_reg <= `ETT_RELOAD_RST;
			shared_reg <= `ETT_SHARED_RST;
		end else begin
			if (wr && hit_reload) begin
				reload_reg <= pwdata[7:0];
			end
			if (wr && hit_shared) begin
				shared_reg <= pwdata[7:5];
			end
		end
	end

	// timer output toggles at each terminal count
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_out_reg <= 1'b0;
		end else if (tc) begin
			timer_out_reg <= ~timer_out_reg;
		end
	end

	// pin mux, plain port output by default
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_output_port_pin <= 1'b0;
		end else if (ctrl_reg.pin_sel) begin
			timer_output_port_pin <= timer_out_reg;
		end else begin
			timer_output_port_pin <= port_out_data;
		end
	end

	// interrupt status, set wins over read clear
	// read data is taken in setup, so only a bit that read returned is cleared
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			istat_reg <= 1'b0;
		end else if (tc && ctrl_reg.int_en) begin
			istat_reg <= 1'b1;
		end else if (rd && hit_istat && prdata[0]) begin
			istat_reg <= 1'b0;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			imask_reg <= 1'b0;
		end else if (wr && hit_imask) begin
			imask_reg <= pwdata[0];
		end
	end

	// level interrupt
	assign irq = istat_reg & imask_reg;

	// checks
	start_on_enable_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(wr_ctrl && pwdata[`ETT_EN_BIT] && state_reg == ETT_IDLE)
		|=> (state_reg == ETT_RUN) && (count_reg == $past(reload_reg)))
		else $error("enable write did not start the timer");

	modulo_reload_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(tc && !ctrl_reg.single && !wr_ctrl)
		|=> (state_reg == ETT_RUN) && (count_reg == $past(reload_reg)))
		else $error("modulo mode did not reload");

	single_halt_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(tc && ctrl_reg.single) |=> (state_reg == ETT_IDLE) && (count_reg == 8'h00))
		else $error("single-pass did not halt");

	timeout_set_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		tc |=> ctrl_reg.timeout)
		else $error("timeout flag not set");

	timeout_hold_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(ctrl_reg.timeout && !(wr_ctrl && pwdata[`ETT_TOUT_BIT])) |=> ctrl_reg.timeout)
		else $error("timeout flag lost without write one");

	timeout_clear_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(wr_ctrl && pwdata[`ETT_TOUT_BIT] && !tc) |=> !ctrl_reg.timeout)
		else $error("write one did not clear timeout");

	prescale_free_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$rose(state_reg == ETT_RUN) |-> (div_reg == 4'($past(div_reg) + 4'h1)))
		else $error("prescaler restarted on enable");

	clock_select_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(tick && ctrl_reg.clk_sel == 2'd3) |-> (div_reg[2:0] == 3'h7))
		else $error("divide by eight ticked early");

	int_gate_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(!istat_reg && !(tc && ctrl_reg.int_en)) |=> !istat_reg)
		else $error("interrupt status set while disabled");

	pin_route_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ctrl_reg.pin_sel |=> (timer_output_port_pin == $past(timer_out_reg)))
		else $error("timer output not routed to pin");

	pin_port_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!ctrl_reg.pin_sel |=> (timer_output_port_pin == $past(port_out_data)))
		else $error("port data not routed to pin");

	istat_clear_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(rd && hit_istat && prdata[0] && !(tc && ctrl_reg.int_en)) |=> !istat_reg)
		else $error("status read did not clear interrupt");

	istat_keep_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(istat_reg && !(rd && hit_istat && prdata[0])) |=> istat_reg)
		else $error("interrupt status lost without read");

endmodule : ett_timer8

// file: rtl/ett_map.svh
/*
 * Address map, field positions and reset values of the 8-bit timer block.
 * Assumes APB with byte addresses and 32-bit data; each index is one word.
 */
`ifndef ETT_MAP_SVH
`define ETT_MAP_SVH
// register indexes, byte address is four times the index
`define ETT_CTRL_IDX    6'h00
`define ETT_SHARED_IDX  6'h03
`define ETT_RELOAD_IDX  6'h04
`define ETT_COUNT_IDX   6'h05
`define ETT_ISTAT_IDX   6'h06
`define ETT_IMASK_IDX   6'h07
// timer8_control field positions
`define ETT_EN_BIT      7
`define ETT_SINGLE_BIT  6
`define ETT_TOUT_BIT    5
`define ETT_CSEL_HI     4
`define ETT_CSEL_LO     3
`define ETT_INTEN_BIT   1
`define ETT_PINSEL_BIT  0
// reset values
`define ETT_RELOAD_RST  8'h00
`define ETT_SHARED_RST  3'h0
`define ETT_SHARED_RSV  5'h1f
`endif

// file: rtl/ett_pkg.sv
/*
 * Types shared by the 8-bit timer block.
 * Assumes the map header supplies all numeric constants.
 */
package ett_pkg;
	// stored control fields, enable lives in the state machine
	typedef struct packed {
		logic       single;  // single-pass when set
		logic       timeout; // sticky terminal-count flag
		logic [1:0] clk_sel; // input clock divide select
		logic       int_en;  // timeout interrupt enable
		logic       pin_sel; // timer output onto port pin
	} ett_ctrl_t;

	// timer run state
	typedef enum logic [0:0] {
		ETT_IDLE = 1'b0,
		ETT_RUN  = 1'b1
	} ett_state_t;
endpackage : ett_pkg

// file: test/ett_timer8_bench.sv
/*
 * self-checking bench for the 8-bit timer block, driven over apb.
 * assumes the zero-wait slave and the register map of the map header.
 */
`timescale 1ns/100ps
`include "ett_map.svh"
// compare one value, count it, report a mismatch
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module ett_timer8_bench import ett_pkg::*; ;
	localparam logic [7:0] A_CTRL = {`ETT_CTRL_IDX, 2'b00};   // control
	localparam logic [7:0] A_SHR  = {`ETT_SHARED_IDX, 2'b00}; // shared control
	localparam logic [7:0] A_RLD  = {`ETT_RELOAD_IDX, 2'b00}; // initial count
	localparam logic [7:0] A_CNT  = {`ETT_COUNT_IDX, 2'b00};  // live count
	localparam logic [7:0] A_IST  = {`ETT_ISTAT_IDX, 2'b00};  // irq status
	localparam logic [7:0] A_MSK  = {`ETT_IMASK_IDX, 2'b00};  // irq mask
	logic        mclk, sys_rst, psel, penable, pwrite, port_out_data;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, irq, pin, rerr, p;
	int          errors, checks, d;

	ett_timer8 i_ett_timer8 (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.port_out_data(port_out_data), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .timer_output_port_pin(pin));

	// 25 ns clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// one apb transfer, waits for pready, keeps read data and error
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// control word from its fields
	function automatic logic [31:0] cw(int en, sg, to, cs, ie, ps);
		cw = '0;
		cw[`ETT_EN_BIT] = en[0];
		cw[`ETT_SINGLE_BIT] = sg[0];
		cw[`ETT_TOUT_BIT] = to[0];
		cw[`ETT_CSEL_HI:`ETT_CSEL_LO] = cs[1:0];
		cw[`ETT_INTEN_BIT] = ie[0];
		cw[`ETT_PINSEL_BIT] = ps[0];
	endfunction : cw

	// poll control until timeout flag shows, bounded
	task automatic wait_tout;
		for (int n = 0; n < 120; n++) begin
			apb(1'b0, A_CTRL, '0);
			if (rdat[`ETT_TOUT_BIT] === 1'b1) break;
		end
		`CHK("timeout flag", 1'b1, rdat[`ETT_TOUT_BIT])
	endtask : wait_tout

	// reset values, reserved bits, refused addresses
	task automatic t_reset;
		apb(1'b0, A_CTRL, '0);
		`CHK("pin_sel reset", 1'b0, rdat[`ETT_PINSEL_BIT])
		`CHK("pin reset", 1'b0, pin)
		`CHK("pready high", 1'b1, pready)
		apb(1'b1, A_SHR, 32'h0000_0000);
		apb(1'b0, A_SHR, '0);
		`CHK("shared reserved", 5'h1f, rdat[4:0])
		apb(1'b0, 8'h08, '0);
		`CHK("unmapped err", 1'b1, rerr)
		`CHK("unmapped data", 32'h0, rdat)
		apb(1'b1, 8'h01, 32'h0000_00ff);
		`CHK("misaligned err", 1'b1, rerr)
		$display("test reset done");
	endtask : t_reset

	// modulo mode keeps running, flag write-one-to-clear
	// divide by eight keeps the next terminal count far from the clear
	task automatic t_modulo;
		apb(1'b1, A_RLD, 32'h14);
		apb(1'b1, A_CTRL, cw(1, 0, 1, 3, 0, 0));
		wait_tout();
		`CHK("still running", 1'b1, rdat[`ETT_EN_BIT])
		apb(1'b1, A_CTRL, cw(1, 0, 0, 3, 0, 0));
		apb(1'b0, A_CTRL, '0);
		`CHK("zero keeps flag", 1'b1, rdat[`ETT_TOUT_BIT])
		apb(1'b1, A_CTRL, cw(1, 0, 1, 3, 0, 0));
		apb(1'b0, A_CTRL, '0);
		`CHK("one clears flag", 1'b0, rdat[`ETT_TOUT_BIT])
		wait_tout();
		apb(1'b1, A_CTRL, cw(0, 0, 1, 0, 0, 0));
		$display("test modulo done");
	endtask : t_modulo

	// single-pass halts at terminal count
	task automatic t_single;
		apb(1'b1, A_RLD, 32'h0a);
		apb(1'b1, A_CTRL, cw(1, 1, 1, 0, 0, 0));
		apb(1'b0, A_CTRL, '0);
		`CHK("enable starts", 1'b1, rdat[`ETT_EN_BIT])
		wait_tout();
		apb(1'b0, A_CTRL, '0);
		`CHK("halted", 1'b0, rdat[`ETT_EN_BIT])
		apb(1'b0, A_CNT, '0);
		`CHK("count held zero", 8'h00, rdat[7:0])
		$display("test single done");
	endtask : t_single

	// interrupt raised, cleared by read, gated by enable and mask
	task automatic t_irq;
		apb(1'b1, A_MSK, 32'h1);
		apb(1'b1, A_RLD, 32'h04);
		apb(1'b1, A_CTRL, cw(1, 1, 1, 0, 1, 0));
		for (int n = 0; n < 40 && irq !== 1'b1; n++) @(negedge mclk);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b0, A_IST, '0);
		`CHK("istat set", 1'b1, rdat[0])
		@(negedge mclk);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b1, A_CTRL, cw(1, 1, 1, 0, 0, 0));
		wait_tout();
		apb(1'b0, A_IST, '0);
		`CHK("no istat when off", 1'b0, rdat[0])
		apb(1'b1, A_MSK, 32'h0);
		apb(1'b1, A_CTRL, cw(1, 1, 1, 0, 1, 0));
		wait_tout();
		`CHK("masked irq low", 1'b0, irq)
		apb(1'b0, A_IST, '0);
		`CHK("masked istat set", 1'b1, rdat[0])
		$display("test irq done");
	endtask : t_irq

	// pin follows port data, or the toggling timer output
	task automatic t_pin;
		apb(1'b1, A_CTRL, cw(0, 0, 1, 0, 0, 0));
		for (int v = 0; v < 2; v++) begin
			@(posedge mclk) port_out_data <= ~v[0];
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			`CHK("pin port data", ~v[0], pin)
		end
		apb(1'b1, A_RLD, 32'h00);
		apb(1'b1, A_CTRL, cw(1, 0, 1, 0, 0, 1));
		// pin shows the timer output from the second cycle on
		repeat (2) @(negedge mclk);
		p = pin;
		@(negedge mclk);
		`CHK("pin timer toggles", ~p, pin)
		apb(1'b1, A_CTRL, cw(0, 0, 1, 0, 0, 0));
		$display("test pin done");
	endtask : t_pin

	// every clock select, ticks over 40 cycles
	task automatic t_csel;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, A_RLD, 32'hc8);
			apb(1'b1, A_CTRL, cw(1, 0, 1, s, 0, 0));
			repeat (40) @(posedge mclk);
			apb(1'b0, A_CNT, '0);
			d = 200 - int'(rdat[7:0]);
			`CHK("tick rate", 1'b1, (d >= (40 >> s) - 1 && d <= (40 >> s) + 2))
			apb(1'b1, A_CTRL, cw(0, 0, 1, 0, 0, 0));
		end
		$display("test csel done");
	endtask : t_csel

	// counts and verdict, ends the run
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		errors = 0; checks = 0;
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; port_out_data = 1'b0;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_modulo();
		t_single();
		t_irq();
		t_pin();
		t_csel();
		print_verdict();
	end

	// hang guard, far beyond the less than one thousand cycles the tests take
	initial begin
		#(25 * 30000);
		errors++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule : ett_timer8_bench
